// ---- hw/lecc_pkg.sv ----
// Purpose: Shared constants and types for the lane error counter block
// Assumes: Register indices are word indices; byte address is index * 4
// Notes:   Error bit order inside each lane field is fixed by the struct
package lecc_pkg;

  localparam int LANES    = 4;
  localparam int ERR_BITS = 3;
  localparam int CNT_W    = 8;
  localparam int IDX_W    = 14;

  localparam logic [CNT_W-1:0] TERMINAL_COUNT = 8'hFF;
  localparam logic [CNT_W-1:0] COUNT_RESET    = 8'h00;

  // Bit positions inside a lane field
  localparam int CTRL_CHAR_BIT = 2;
  localparam int BAD_CODE_BIT  = 1;
  localparam int DISPARITY_BIT = 0;
  localparam int LANE_ON_BIT   = 3;

  localparam logic [ERR_BITS-1:0] HOLD_RESET    = 3'h7;
  localparam logic [ERR_BITS-1:0] TC_FLAG_RESET = 3'h0;
  localparam logic [7:0]          STAT_RESET = 8'h00;

  // Register indices, slot order is lane 0, 5, 6, 7
  localparam logic [LANES-1:0][IDX_W-1:0] HOLD_IDX =
    {14'h048F, 14'h048E, 14'h048D, 14'h0488};
  localparam logic [LANES-1:0][IDX_W-1:0] STAT_IDX =
    {14'h0497, 14'h0496, 14'h0495, 14'h0490};
  localparam logic [IDX_W-1:0] IDX_CNT_CLR  = 14'h04A0;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 14'h04A1;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 14'h04A2;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 14'h04A3;

  localparam logic [11:0] IRQ_EN_RESET   = 12'h000;
  localparam logic [11:0] IRQ_STAT_RESET = 12'h000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One lane's error strobes, MSB first
  typedef struct packed {
    logic unexpected_control_char_error;
    logic invalid_code_error;
    logic disparity_error;
  } lecc_err_t;

endpackage

// ---- hw/lecc_rst_sync.sv ----
// Purpose: Release of the asynchronous reset through two flip-flops
// Assumes: rst_b is active low and may change at any time
// Notes:   Assertion is asynchronous, release is synchronous
`timescale 1ns/1ps
module lecc_rst_sync (
  // Clock and raw reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Synchronised reset
  output logic      rst_n
);

  logic meta_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      rst_n    <= meta_reg;
    end
  end

endmodule

// ---- hw/lecc_err_counter.sv ----
// Purpose: One 8-bit error counter with hold or roll-over at terminal count
// Assumes: err_in is a one-cycle strobe on clk_sys
// Notes:   clear also drops the terminal-reached flag
`timescale 1ns/1ps
module lecc_err_counter (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // Control
  input  wire logic                    err_in,
  input  wire logic                    hold_en,
  input  wire logic                    clear,
  // Status
  output logic [lecc_pkg::CNT_W-1:0]   count,
  output logic                         tc_reached,
  output logic                         tc_event
);

  logic [lecc_pkg::CNT_W-1:0] count_next;
  logic                       tcr_next;
  logic                       ev_next;

  always_comb begin
    count_next = count;
    tcr_next   = tc_reached;
    ev_next    = 1'b0;
    if (clear) begin
      count_next = lecc_pkg::COUNT_RESET;
      tcr_next   = 1'b0;
    end else if (err_in) begin
      if (count == lecc_pkg::TERMINAL_COUNT) begin
        if (!hold_en) begin
          count_next = lecc_pkg::COUNT_RESET; // RQ2
        end
      end else begin
        count_next = count + 8'h01; // RQ8
        if (count == lecc_pkg::TERMINAL_COUNT - 8'h01) begin
          tcr_next = 1'b1; // RQ6
          ev_next  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count      <= lecc_pkg::COUNT_RESET;
      tc_reached <= 1'b0;
      tc_event   <= 1'b0;
    end else begin
      count      <= count_next; // RQ1
      tc_reached <= tcr_next;
      tc_event   <= ev_next;
    end
  end

  hold_at_tc_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ1
    (count == 8'hFF && hold_en && !clear) |=> (count == 8'hFF))
    else $error("counter left terminal count while hold set");

  wrap_to_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ2
    (count == 8'hFF && !hold_en && err_in && !clear) |=> (count == 8'h00))
    else $error("counter did not roll over");

  count_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ8
    (count != 8'hFF && err_in && !clear) |=> (count == $past(count) + 8'h01))
    else $error("counter did not step by one");

  tc_flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
    (count == 8'hFE && err_in && !clear) |=> (tc_reached && tc_event))
    else $error("terminal reached flag not set");

endmodule

// ---- hw/lecc_top.sv ----
// Purpose: AXI4-Lite register bank and error counters for lanes 0, 5, 6, 7
// Assumes: Error strobes and soft resets come from logic on clk_sys
// Notes:   Registers are 8-bit, in the low byte of each aligned word
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// [RQ1] Hold enabled: counter stops at 0xFF
// [RQ2] Hold cleared: counter rolls over to zero
// [RQ3] Bit 2 control char, 1 table, 0 disparity
// [RQ4] Software changes hold only during soft reset; the code accepts hold writes at any time
// [RQ5] Per-lane 3-bit hold field, resets to 0x7
// [RQ6] Terminal reached bit set at 0xFF, resets 0
// [RQ7] Status bit 3 shows lane enabled
// [RQ8] Eight-bit counter steps once per error
module lecc_top (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  // AXI4-Lite write address
  input  wire logic [15:0]                   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [15:0]                   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Lane decoder side
  input  wire lecc_pkg::lecc_err_t [3:0]     lane_err,
  input  wire logic [3:0]                    lane_soft_reset,
  // Interrupt
  output logic                               irq
);

  function automatic logic [lecc_pkg::IDX_W-1:0] reg_index(
    input logic [15:0] addr
  );
    reg_index = addr[15:2];
  endfunction

  logic rst_n;

  lecc_rst_sync u_rst_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .rst_n   (rst_n)
  );

  // Register state
  logic [3:0][2:0] hold_reg;
  logic [3:0][2:0] hold_next;
  logic [11:0]     irq_en_reg;
  logic [11:0]     irq_en_next;
  logic [11:0]     irq_stat_reg;
  logic [11:0]     irq_stat_next;
  logic [3:0]      clr_reg;
  logic [3:0]      clr_next;
  logic            irq_next;

  // Write channel state
  logic            aw_full_reg;
  logic            aw_full_next;
  logic [15:0]     awaddr_reg;
  logic [15:0]     awaddr_next;
  logic            w_full_reg;
  logic            w_full_next;
  logic [7:0]      wdata_reg;
  logic [7:0]      wdata_next;
  logic            wstrb0_reg;
  logic            wstrb0_next;
  logic            awready_next;
  logic            wready_next;
  logic            bvalid_next;
  logic [1:0]      bresp_next;
  logic            do_write;
  logic            wr_hit;

  // Read channel state
  logic            arready_next;
  logic            rvalid_next;
  logic [31:0]     rdata_next;
  logic [1:0]      rresp_next;
  logic [7:0]      rd_byte;
  logic            rd_hit;

  // Counter status
  logic [3:0][2:0] tcr;
  logic [11:0]     tc_ev;

  for (genvar l = 0; l < lecc_pkg::LANES; l++) begin : g_lane
    for (genvar b = 0; b < lecc_pkg::ERR_BITS; b++) begin : g_err
      lecc_err_counter u_cnt (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .err_in     (lane_err[l][b]), // RQ3
        .hold_en    (hold_reg[l][b]), // RQ1
        .clear      (clr_reg[l] | lane_soft_reset[l]),
        .count      (),
        .tc_reached (tcr[l][b]),
        .tc_event   (tc_ev[l*3+b])
      );
    end
  end

  // Write path
  always_comb begin
    aw_full_next = aw_full_reg;
    awaddr_next  = awaddr_reg;
    w_full_next  = w_full_reg;
    wdata_next   = wdata_reg;
    wstrb0_next  = wstrb0_reg;
    bvalid_next  = s_axi_bvalid;
    bresp_next   = s_axi_bresp;
    hold_next    = hold_reg;
    irq_en_next  = irq_en_reg;
    clr_next     = 4'h0;
    wr_hit       = 1'b0;
    do_write     = aw_full_reg && w_full_reg && !s_axi_bvalid;
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata[7:0];
      wstrb0_next = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      for (int l = 0; l < lecc_pkg::LANES; l++) begin
        if (reg_index(awaddr_reg) == lecc_pkg::HOLD_IDX[l]) begin
          wr_hit = 1'b1;
          if (wstrb0_reg) begin
            hold_next[l] = wdata_reg[2:0]; // RQ5
          end
        end
        if (reg_index(awaddr_reg) == lecc_pkg::STAT_IDX[l]) begin
          wr_hit = 1'b1;
        end
      end
      unique case (reg_index(awaddr_reg))
        lecc_pkg::IDX_CNT_CLR: begin
          wr_hit = 1'b1;
          if (wstrb0_reg) begin
            clr_next = wdata_reg[3:0];
          end
        end
        lecc_pkg::IDX_IRQ_EN: begin
          wr_hit = 1'b1;
          if (wstrb0_reg) begin
            irq_en_next = {irq_en_reg[11:8], wdata_reg};
          end
        end
        lecc_pkg::IDX_IRQ_CLR, lecc_pkg::IDX_IRQ_STAT: begin
          wr_hit = 1'b1;
        end
        default: begin
          wr_hit = wr_hit;
        end
      endcase
      bresp_next = wr_hit ? lecc_pkg::RESP_OKAY : lecc_pkg::RESP_SLVERR;
    end
    awready_next = !aw_full_next;
    wready_next  = !w_full_next;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_reg   <= 1'b0;
      awaddr_reg    <= 16'h0000;
      w_full_reg    <= 1'b0;
      wdata_reg     <= 8'h00;
      wstrb0_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lecc_pkg::RESP_OKAY;
      hold_reg      <= {4{lecc_pkg::HOLD_RESET}};
      irq_en_reg    <= lecc_pkg::IRQ_EN_RESET;
      clr_reg       <= 4'h0;
    end else begin
      aw_full_reg   <= aw_full_next;
      awaddr_reg    <= awaddr_next;
      w_full_reg    <= w_full_next;
      wdata_reg     <= wdata_next;
      wstrb0_reg    <= wstrb0_next;
      s_axi_awready <= awready_next;
      s_axi_wready  <= wready_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_bresp   <= bresp_next;
      hold_reg      <= hold_next;
      irq_en_reg    <= irq_en_next;
      clr_reg       <= clr_next;
    end
  end

  // Read path
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b0;
    for (int l = 0; l < lecc_pkg::LANES; l++) begin
      if (reg_index(s_axi_araddr) == lecc_pkg::HOLD_IDX[l]) begin
        rd_hit  = 1'b1;
        rd_byte = {5'h00, hold_reg[l]};
      end
      if (reg_index(s_axi_araddr) == lecc_pkg::STAT_IDX[l]) begin
        rd_hit  = 1'b1;
        rd_byte = {4'h0, !lane_soft_reset[l], tcr[l]}; // RQ7
      end
    end
    unique case (reg_index(s_axi_araddr))
      lecc_pkg::IDX_IRQ_STAT: begin
        rd_hit  = 1'b1;
        rd_byte = irq_stat_reg[7:0];
      end
      lecc_pkg::IDX_IRQ_EN: begin
        rd_hit  = 1'b1;
        rd_byte = irq_en_reg[7:0];
      end
      lecc_pkg::IDX_CNT_CLR, lecc_pkg::IDX_IRQ_CLR: begin
        rd_hit  = 1'b1;
      end
      default: begin
        rd_hit  = rd_hit;
      end
    endcase
  end

  always_comb begin
    arready_next = s_axi_arready || !s_axi_rvalid;
    rvalid_next  = s_axi_rvalid;
    rdata_next   = s_axi_rdata;
    rresp_next   = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rdata_next   = {24'h000000, rd_byte};
      rresp_next   = rd_hit ? lecc_pkg::RESP_OKAY : lecc_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= lecc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= arready_next;
      s_axi_rvalid  <= rvalid_next;
      s_axi_rdata   <= rdata_next;
      s_axi_rresp   <= rresp_next;
    end
  end

  // Interrupt status, new events win over a clear in the same cycle
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (do_write && wstrb0_reg &&
        reg_index(awaddr_reg) == lecc_pkg::IDX_IRQ_CLR) begin
      irq_stat_next = irq_stat_reg & ~{4'h0, wdata_reg};
    end
    irq_stat_next = irq_stat_next | tc_ev; // RQ6
    irq_next      = |(irq_stat_reg & irq_en_reg);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= lecc_pkg::IRQ_STAT_RESET;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq          <= irq_next;
    end
  end

  hold_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
    $rose(rst_n) |-> (hold_reg == {4{3'h7}}))
    else $error("hold field not all ones after reset");

  err_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
    tc_ev[2] |=> (irq_stat_reg[2] && tcr[0][2]))
    else $error("control char counter not on bit 2");

  lane_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ7
    (s_axi_arvalid && s_axi_arready &&
     reg_index(s_axi_araddr) == 14'h0490)
    |=> (s_axi_rdata[3] == !$past(lane_soft_reset[0])))
    else $error("lane enable bit wrong");

  write_cov: cover property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_bvalid && s_axi_bready);
  read_cov: cover property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rready);
  irq_cov: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(irq));

endmodule

// ---- verification/lecc_lane_model.sv ----
// Purpose: Lane decoder model driving error strobes and soft resets
// Assumes: Strobes are one-cycle pulses on clk_sys
// Notes:   Bursts are back to back, one error per cycle
`timescale 1ns/1ps
module lecc_lane_model (
  // Clock
  input  wire logic                 clk_sys,
  // Decoder side
  output lecc_pkg::lecc_err_t [3:0] lane_err,
  output logic [3:0]                lane_soft_reset
);
  initial begin
    lane_err = '0;
    lane_soft_reset = 4'hF;
  end

  // Burst of n errors of the given kinds on one slot
  task automatic burst(input int slot, input logic [2:0] kind, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      lane_err[slot] <= kind;
    end
    @(posedge clk_sys);
    lane_err[slot] <= 3'h0;
  endtask

  task automatic soft_reset(input int slot, input logic lvl);
    @(posedge clk_sys);
    lane_soft_reset[slot] <= lvl;
  endtask
endmodule

// ---- verification/test_lane_error_counter_control.sv ----
// Purpose: Self-checking bench for the lane error counter register bank
// Assumes: Byte address is four times the register index
// Notes:   Counters are seen only through flags and irq status
`timescale 1ns/1ps
module test_lane_error_counter_control;
  logic                      clk_sys, rst_b, irq;
  logic [15:0]               s_axi_awaddr, s_axi_araddr;
  logic [31:0]               s_axi_wdata, s_axi_rdata;
  logic [3:0]                s_axi_wstrb, lane_soft_reset;
  logic [1:0]                s_axi_bresp, s_axi_rresp;
  logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                      s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                      s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                      s_axi_rready;
  lecc_pkg::lecc_err_t [3:0] lane_err;
  int                        errors, samples_checked;
  logic [7:0]                ex;
  localparam logic [1:0]  OK = lecc_pkg::RESP_OKAY;
  localparam logic [1:0]  SE = lecc_pkg::RESP_SLVERR;
  localparam logic [15:0] HOLD0 = {lecc_pkg::HOLD_IDX[0], 2'b00};
  localparam logic [15:0] HOLD5 = 16'h1234;
  localparam logic [15:0] HOLD6 = 16'h1238;
  localparam logic [15:0] HOLD7 = 16'h123C;
  localparam logic [15:0] STAT0 = 16'h1240;
  localparam logic [15:0] CLR   = {lecc_pkg::IDX_CNT_CLR, 2'b00};
  localparam logic [15:0] ISTAT = {lecc_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [15:0] IEN   = {lecc_pkg::IDX_IRQ_EN, 2'b00};
  localparam logic [15:0] ICLR  = {lecc_pkg::IDX_IRQ_CLR, 2'b00};
  localparam logic [15:0] HOLDS [4] = '{HOLD0, HOLD5, HOLD6, HOLD7};

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  lecc_top dut (
    .clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .lane_err, .lane_soft_reset, .irq
  );

  lecc_lane_model lanes (.clk_sys, .lane_err, .lane_soft_reset);

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Wait at falling edges for bvalid, rvalid or arready
  task automatic await(input int s);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n >= 200) begin
        errors++;
        $display("TIMEOUT t=%0t waiting on handshake %0d", $time, s);
        tally_and_finish();
      end
    end while ((s == 0 ? s_axi_bvalid :
                s == 1 ? s_axi_rvalid : s_axi_arready) !== 1'b1);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    logic da, dw, ta, tw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; !(da && dw); n++) begin
      @(negedge clk_sys);
      ta = !da && (s_axi_awready === 1'b1);
      tw = !dw && (s_axi_wready === 1'b1);
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
      if (n >= 200) begin
        errors++;
        $display("TIMEOUT t=%0t waiting on write address or data", $time);
        tally_and_finish();
      end
    end
    await(0);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] ed,
                        input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    await(2);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    await(1);
    chk(s_axi_rdata, {24'h0, ed});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask

  // Flag one edge after the pulse, irq two more
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  initial begin
    errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    s_axi_awaddr = 16'h0000;
    s_axi_araddr = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    await(2);
    for (int i = 0; i < 4; i++) begin
      rd_chk(HOLDS[i], 8'h07, OK);
    end
    rd_chk(STAT0, 8'h00, OK);
    rd_chk(16'h0000, 8'h00, SE);
    wr(HOLD6, 8'hFA, OK);
    rd_chk(HOLD6, 8'h02, OK);
    s_axi_wstrb <= 4'h0;
    wr(HOLD6, 8'h07, OK);
    rd_chk(HOLD6, 8'h02, OK);
    s_axi_wstrb <= 4'h1;
    wr(HOLD7, 8'h05, OK);
    rd_chk(HOLD7, 8'h05, OK);
    wr(HOLD5, 8'h00, OK);
    rd_chk(HOLD5, 8'h00, OK);
    wr(STAT0, 8'hFF, OK);
    rd_chk(STAT0, 8'h00, OK);
    wr(16'h0000, 8'h11, SE);
    $display("TEST registers done");
    lanes.soft_reset(0, 1'b0);
    rd_chk(STAT0, 8'h08, OK);
    ex = 8'h08;
    for (int k = 0; k < 3; k++) begin
      lanes.burst(0, 3'(1 << k), 254);
      rd_chk(STAT0, ex, OK);
      lanes.burst(0, 3'(1 << k), 1);
      ex = ex | (8'h01 << k);
      rd_chk(STAT0, ex, OK);
    end
    $display("TEST terminal count mapping done");
    rd_chk(ISTAT, 8'h07, OK);
    wr(IEN, 8'h07, OK);
    irq_is(1'b1);
    wr(IEN, 8'h00, OK);
    irq_is(1'b0);
    wr(ICLR, 8'h07, OK);
    rd_chk(ISTAT, 8'h00, OK);
    wr(IEN, 8'h07, OK);
    lanes.burst(0, 3'h7, 256);
    rd_chk(ISTAT, 8'h00, OK);
    irq_is(1'b0);
    $display("TEST hold and interrupt done");
    lanes.soft_reset(0, 1'b1);
    rd_chk(STAT0, 8'h00, OK);
    wr(HOLD0, 8'h06, OK);
    lanes.soft_reset(0, 1'b0);
    lanes.burst(0, 3'h5, 255);
    rd_chk(ISTAT, 8'h05, OK);
    wr(ICLR, 8'h05, OK);
    lanes.burst(0, 3'h5, 256);
    rd_chk(ISTAT, 8'h01, OK);
    irq_is(1'b1);
    rd_chk(STAT0, 8'h0D, OK);
    wr(CLR, 8'h01, OK);
    rd_chk(STAT0, 8'h08, OK);
    lanes.soft_reset(1, 1'b0);
    lanes.burst(1, 3'h2, 255);
    rd_chk(ISTAT, 8'h11, OK);
    $display("TEST roll-over and clear done");
    tally_and_finish();
  end
endmodule
